// *** fifo_irq_pkg.sv ***
// Constants shared by the FIFO port interrupt, pattern and mailbox logic.
// Assumes one register word per 32-bit AHB-Lite address, byte data in bits 7:0.
package fifo_irq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0] PAT_BYTE_ADDR = 8'h00;
  localparam logic [7:0] PAT_MASK_ADDR = 8'h04;
  localparam logic [7:0] MBOX_OUT_ADDR = 8'h08;
  localparam logic [7:0] MBOX_IN_ADDR = 8'h0C;
  localparam logic [7:0] ISR0_ADDR = 8'h10;
  localparam logic [7:0] ISR1_ADDR = 8'h14;
  localparam logic [7:0] ISR2_ADDR = 8'h18;
  localparam logic [7:0] ISR3_ADDR = 8'h1C;
  localparam logic [7:0] VECTOR_ADDR = 8'h20;
  localparam logic [7:0] CTRL_ADDR = 8'h24;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions inside the status, control and vector registers
  localparam int HI_BASE = 5;
  localparam int LO_BASE = 1;
  localparam int IUS_OFS = 2;
  localparam int IE_OFS = 1;
  localparam int IP_OFS = 0;
  localparam int ISR1_FLAG_BIT = 0;
  localparam int ISR2_OVF_BIT = 4;
  localparam int ISR2_UNF_BIT = 0;
  localparam int ISR3_FULL_BIT = 4;
  localparam int ISR3_EMPTY_BIT = 0;
  localparam int CTRL_MIE_BIT = 0;
  localparam int CTRL_VIS_BIT = 1;
  localparam int VEC_CODE_LSB = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Sources, status code equals index plus one
  localparam int NUM_SRC = 7;
  localparam int SRC_EMPTY = 0;
  localparam int SRC_FULL = 1;
  localparam int SRC_ERROR = 2;
  localparam int SRC_COUNT = 3;
  localparam int SRC_PATTERN = 4;
  localparam int SRC_DIR = 5;
  localparam int SRC_MBOX = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and AHB-Lite transfer types
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [6:0] SRC_RST = 7'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  typedef enum logic [0:0] {BUS_IDLE, BUS_READ} bus_state_t;

endpackage

// *** pattern_matcher.sv ***
// Masked compare of the data buffer byte against the pattern byte.
// Assumes the data buffer byte is presented synchronously by the FIFO datapath.
`timescale 1ns/1ps
module pattern_matcher
  import fifo_irq_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] dataByte,
  input wire logic [WIDTH-1:0] patternByte,
  input wire logic [WIDTH-1:0] ignoreMask,
  output logic trueMatch
);

  logic [WIDTH-1:0] bitOk;

  // A set mask bit counts as agreeing, so all ones always matches
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign bitOk[i] = ignoreMask[i] | (dataByte[i] ~^ patternByte[i]);
    end
  endgenerate

  assign trueMatch = &bitOk;

endmodule

// *** irq_priority.sv ***
// Priority encoder for the seven interrupt sources.
// Assumes status code equals source index plus one; highest index wins.
`timescale 1ns/1ps
module irq_priority
  import fifo_irq_pkg::*;
(
  input wire logic [NUM_SRC-1:0] candidate,
  output logic [2:0] code,
  output logic anyActive
);

  always_comb begin
    code = 3'h0;
    for (int s = 0; s < NUM_SRC; s++) begin
      if (candidate[s]) begin
        code = 3'(s + 1);
      end
    end
  end

  assign anyActive = |candidate;

endmodule

// *** fifo_irq_status.sv ***
// Interrupt, pattern compare and mailbox logic for one FIFO port.
// Assumes FIFO status, byte strobes and the opposite port's mailbox
// arrive synchronous to ref_clk; registers reached over AHB-Lite.
//
// Our own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module fifo_irq_status
  import fifo_irq_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] dataByte,
  input wire logic bytePassed,
  input wire logic [CNT_W-1:0] byteCount,
  input wire logic [CNT_W-1:0] byteCountCompare,
  input wire logic bufferFull,
  input wire logic bufferEmpty,
  input wire logic fullPin,
  input wire logic emptyPin,
  input wire logic twoWireMode,
  input wire logic peripheralMode,
  input wire logic waitSelected,
  input wire logic writeAttempt,
  input wire logic readAttempt,
  input wire logic directionChanged,
  input wire logic [7:0] mailboxFromOther,
  input wire logic mailboxFromOtherStrobe,
  input wire logic irq_acknowledge_in_n,
  output logic [7:0] mailboxToOther,
  output logic mailboxToOtherStrobe,
  output logic irqRequest,
  output logic [7:0] vectorOut,
  output logic vectorOe
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus state
  bus_state_t busState_ff;
  logic [7:0] addr_ff;
  logic wrPend_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic hresp_ff;
  logic addrTaken;
  logic writeNow;
  logic [7:0] wByte;
  logic readDone;

  // Block registers
  logic [7:0] patternByte_ff;
  logic [7:0] patternMask_ff;
  logic [7:0] mboxOut_ff;
  logic [7:0] mboxIn_ff;
  logic [7:0] baseVector_ff;
  logic master_irq_enable_ff;
  logic vector_carries_status_ff;
  logic [NUM_SRC-1:0] source_in_service_bit_ff;
  logic [NUM_SRC-1:0] source_enable_bit_ff;
  logic [NUM_SRC-1:0] source_pending_bit_ff;
  logic [NUM_SRC-1:0] nxt_inService;
  logic [NUM_SRC-1:0] nxt_enable;
  logic [NUM_SRC-1:0] nxt_pending;
  logic [NUM_SRC-1:0] srcEvent;
  logic [NUM_SRC-1:0] srcAckSet;
  logic overflow_ff;
  logic underflow_ff;
  logic mboxStrobe_ff;
  logic irqRequest_ff;
  logic [7:0] vectorOut_ff;
  logic vectorOe_ff;
  logic ackSeen_ff;

  // Live conditions
  logic trueMatch;
  logic fullFlag;
  logic emptyFlag;
  logic [2:0] statusCode;
  logic anyActive;
  logic anyInService;
  logic [7:0] vecWithCode;
  logic [7:0] readByte;
  logic ackStart;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes take no wait state, reads take one
  assign addrTaken = hsel & hready & htrans[1];
  assign writeNow = wrPend_ff;
  assign wByte = hwdata[7:0];
  assign readDone = (busState_ff == BUS_READ);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busState_ff <= BUS_IDLE;
      addr_ff <= BYTE_RST;
      wrPend_ff <= 1'b0;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      wrPend_ff <= addrTaken & hwrite;
      hresp_ff <= 1'b0;
      case (busState_ff)
        BUS_IDLE: begin
          if (addrTaken) begin
            addr_ff <= haddr[7:0];
            if (!hwrite) begin
              busState_ff <= BUS_READ;
              hreadyout_ff <= 1'b0;
            end
          end
        end
        BUS_READ: begin
          busState_ff <= BUS_IDLE;
          hreadyout_ff <= 1'b1;
        end
        default: begin
          busState_ff <= BUS_IDLE;
          hreadyout_ff <= 1'b1;
        end
      endcase
    end
  end

  // Read data is sampled a cycle after the address so a write just
  // before it is already stored
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hrdata_ff <= WORD_RST;
    end else if (busState_ff == BUS_READ) begin
      hrdata_ff <= {24'h00_0000, readByte};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pattern compare
  pattern_matcher #(
    .WIDTH(8)
  ) u_match (
    .dataByte(dataByte),
    .patternByte(patternByte_ff),
    .ignoreMask(patternMask_ff),
    .trueMatch(trueMatch)
  );

  // Pattern byte has no reset; it powers up undefined
  always_ff @(posedge ref_clk) begin
    if (writeNow && addr_ff == PAT_BYTE_ADDR) begin
      patternByte_ff <= wByte;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      patternMask_ff <= BYTE_RST;
    end else if (writeNow && addr_ff == PAT_MASK_ADDR) begin
      patternMask_ff <= wByte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mailbox
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mboxOut_ff <= BYTE_RST;
      mboxIn_ff <= BYTE_RST;
      mboxStrobe_ff <= 1'b0;
    end else begin
      mboxStrobe_ff <= writeNow && addr_ff == MBOX_OUT_ADDR;
      if (writeNow && addr_ff == MBOX_OUT_ADDR) begin
        mboxOut_ff <= wByte;
      end
      if (mailboxFromOtherStrobe) begin
        mboxIn_ff <= mailboxFromOther;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source conditions
  always_comb begin
    fullFlag = bufferFull & (~twoWireMode | fullPin);
    emptyFlag = bufferEmpty & (~peripheralMode | emptyPin);
    srcEvent = SRC_RST;
    srcEvent[SRC_MBOX] = mailboxFromOtherStrobe;
    srcEvent[SRC_DIR] = directionChanged;
    srcEvent[SRC_PATTERN] = bytePassed & trueMatch;
    srcEvent[SRC_COUNT] = (byteCount == byteCountCompare);
    srcEvent[SRC_ERROR] = ~waitSelected & (writeAttempt & bufferFull
                          | readAttempt & bufferEmpty);
    srcEvent[SRC_FULL] = fullFlag;
    srcEvent[SRC_EMPTY] = emptyFlag;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-source status bits; a hardware set beats a software clear
  genvar s;
  generate
    for (s = 0; s < NUM_SRC; s++) begin : g_src
      localparam logic [7:0] REG_ADDR = 8'(ISR0_ADDR + 8'(4 * ((7 - s) / 2)));
      localparam int BASE = ((s % 2) == 1 || s == SRC_MBOX) ? HI_BASE : LO_BASE;
      logic wrHit;
      assign wrHit = writeNow && addr_ff == REG_ADDR;
      always_comb begin
        nxt_inService[s] = wrHit ? wByte[BASE + IUS_OFS]
                                 : source_in_service_bit_ff[s];
        nxt_inService[s] = nxt_inService[s] | srcAckSet[s];
        nxt_enable[s] = wrHit ? wByte[BASE + IE_OFS] : source_enable_bit_ff[s];
        nxt_pending[s] = wrHit ? wByte[BASE + IP_OFS] : source_pending_bit_ff[s];
        if (s == SRC_MBOX && readDone && addr_ff == MBOX_IN_ADDR) begin
          nxt_pending[s] = 1'b0;
        end
        nxt_pending[s] = nxt_pending[s] | srcEvent[s];
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      source_in_service_bit_ff <= SRC_RST;
      source_enable_bit_ff <= SRC_RST;
      source_pending_bit_ff <= SRC_RST;
    end else begin
      source_in_service_bit_ff <= nxt_inService;
      source_enable_bit_ff <= nxt_enable;
      source_pending_bit_ff <= nxt_pending;
    end
  end

  // Error cause flags live only while the error pending bit stands
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      overflow_ff <= 1'b0;
      underflow_ff <= 1'b0;
    end else begin
      if (!waitSelected && writeAttempt && bufferFull) begin
        overflow_ff <= 1'b1;
      end else if (!nxt_pending[SRC_ERROR]) begin
        overflow_ff <= 1'b0;
      end
      if (!waitSelected && readAttempt && bufferEmpty) begin
        underflow_ff <= 1'b1;
      end else if (!nxt_pending[SRC_ERROR]) begin
        underflow_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and vector registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      master_irq_enable_ff <= 1'b0;
      vector_carries_status_ff <= 1'b0;
      baseVector_ff <= BYTE_RST;
    end else begin
      if (writeNow && addr_ff == CTRL_ADDR) begin
        master_irq_enable_ff <= wByte[CTRL_MIE_BIT];
        vector_carries_status_ff <= wByte[CTRL_VIS_BIT];
      end
      if (writeNow && addr_ff == VECTOR_ADDR) begin
        baseVector_ff <= wByte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Priority and request
  irq_priority u_prio (
    .candidate(source_pending_bit_ff & source_enable_bit_ff),
    .code(statusCode),
    .anyActive(anyActive)
  );

  assign anyInService = |source_in_service_bit_ff;
  assign vecWithCode = {baseVector_ff[7:4], statusCode, baseVector_ff[0]};
  assign ackStart = ~irq_acknowledge_in_n & ~ackSeen_ff;

  // Acknowledge puts the winning source in service
  always_comb begin
    srcAckSet = SRC_RST;
    if (ackStart && master_irq_enable_ff && anyActive && !anyInService) begin
      srcAckSet[statusCode - 3'h1] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irqRequest_ff <= 1'b0;
      ackSeen_ff <= 1'b0;
      vectorOut_ff <= BYTE_RST;
      vectorOe_ff <= 1'b0;
    end else begin
      irqRequest_ff <= master_irq_enable_ff & anyActive & ~anyInService;
      ackSeen_ff <= ~irq_acknowledge_in_n;
      vectorOe_ff <= ~irq_acknowledge_in_n & master_irq_enable_ff;
      if (ackStart) begin
        vectorOut_ff <= vector_carries_status_ff ? vecWithCode : baseVector_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unused bits read zero
  always_comb begin
    readByte = BYTE_RST;
    case (addr_ff)
      PAT_BYTE_ADDR: readByte = patternByte_ff;
      PAT_MASK_ADDR: readByte = patternMask_ff;
      MBOX_OUT_ADDR: readByte = mboxOut_ff;
      MBOX_IN_ADDR: readByte = mboxIn_ff;
      ISR0_ADDR: begin
        readByte[HI_BASE + IUS_OFS] = source_in_service_bit_ff[SRC_MBOX];
        readByte[HI_BASE + IE_OFS] = source_enable_bit_ff[SRC_MBOX];
        readByte[HI_BASE + IP_OFS] = source_pending_bit_ff[SRC_MBOX];
      end
      ISR1_ADDR: begin
        readByte[HI_BASE + IUS_OFS] = source_in_service_bit_ff[SRC_DIR];
        readByte[HI_BASE + IE_OFS] = source_enable_bit_ff[SRC_DIR];
        readByte[HI_BASE + IP_OFS] = source_pending_bit_ff[SRC_DIR];
        readByte[LO_BASE + IUS_OFS] = source_in_service_bit_ff[SRC_PATTERN];
        readByte[LO_BASE + IE_OFS] = source_enable_bit_ff[SRC_PATTERN];
        readByte[LO_BASE + IP_OFS] = source_pending_bit_ff[SRC_PATTERN];
        readByte[ISR1_FLAG_BIT] = trueMatch;
      end
      ISR2_ADDR: begin
        readByte[HI_BASE + IUS_OFS] = source_in_service_bit_ff[SRC_COUNT];
        readByte[HI_BASE + IE_OFS] = source_enable_bit_ff[SRC_COUNT];
        readByte[HI_BASE + IP_OFS] = source_pending_bit_ff[SRC_COUNT];
        readByte[LO_BASE + IUS_OFS] = source_in_service_bit_ff[SRC_ERROR];
        readByte[LO_BASE + IE_OFS] = source_enable_bit_ff[SRC_ERROR];
        readByte[LO_BASE + IP_OFS] = source_pending_bit_ff[SRC_ERROR];
        readByte[ISR2_OVF_BIT] = overflow_ff;
        readByte[ISR2_UNF_BIT] = underflow_ff;
      end
      ISR3_ADDR: begin
        readByte[HI_BASE + IUS_OFS] = source_in_service_bit_ff[SRC_FULL];
        readByte[HI_BASE + IE_OFS] = source_enable_bit_ff[SRC_FULL];
        readByte[HI_BASE + IP_OFS] = source_pending_bit_ff[SRC_FULL];
        readByte[LO_BASE + IUS_OFS] = source_in_service_bit_ff[SRC_EMPTY];
        readByte[LO_BASE + IE_OFS] = source_enable_bit_ff[SRC_EMPTY];
        readByte[LO_BASE + IP_OFS] = source_pending_bit_ff[SRC_EMPTY];
        readByte[ISR3_FULL_BIT] = fullFlag;
        readByte[ISR3_EMPTY_BIT] = emptyFlag;
      end
      VECTOR_ADDR: begin
        readByte = master_irq_enable_ff ? vecWithCode : baseVector_ff;
      end
      CTRL_ADDR: begin
        readByte[CTRL_MIE_BIT] = master_irq_enable_ff;
        readByte[CTRL_VIS_BIT] = vector_carries_status_ff;
      end
      default: readByte = BYTE_RST;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign mailboxToOther = mboxOut_ff;
  assign mailboxToOtherStrobe = mboxStrobe_ff;
  assign irqRequest = irqRequest_ff;
  assign vectorOut = vectorOut_ff;
  assign vectorOe = vectorOe_ff;

endmodule

// *** fifo_irq_status_asserts.sv ***
// Checker for the FIFO port interrupt block: bus timing, mailbox, vector.
// Assumes one AHB-Lite master with hready looped back from hreadyout.
`timescale 1ns/1ps
module fifo_irq_status_checker
  import fifo_irq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic irq_acknowledge_in_n,
  input wire logic [7:0] mailboxToOther,
  input wire logic mailboxToOtherStrobe,
  input wire logic irqRequest,
  input wire logic [7:0] vectorOut,
  input wire logic vectorOe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic addrPh;
  assign addrPh = hsel && hready && htrans[1];
  ////////////////////////////////////////////////////////////////////////////
  read_wait_a: assert property (addrPh && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not two cycles");
  write_nowait_a: assert property (addrPh && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("error response seen");
  rdata_upper_a: assert property (hreadyout |-> hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  rdata_hold_a: assert property ($changed(hrdata) |-> $past(!hreadyout))
    else $error("read data changed outside a read");
  mbox_send_a: assert property (
    addrPh && hwrite && haddr == {24'h0, MBOX_OUT_ADDR}
    |=> ##1 mailboxToOtherStrobe && mailboxToOther == $past(hwdata[7:0]))
    else $error("outgoing mailbox not passed on");
  strobe_pulse_a: assert property (mailboxToOtherStrobe |=> !mailboxToOtherStrobe)
    else $error("mailbox strobe longer than one cycle");
  oe_needs_ack_a: assert property (vectorOe |-> !$past(irq_acknowledge_in_n))
    else $error("vector driven outside acknowledge");
  vec_hold_a: assert property (vectorOe && $past(vectorOe) |-> $stable(vectorOut))
    else $error("vector changed while driven");
  ack_block_a: assert property (
    $fell(irq_acknowledge_in_n) ##1 vectorOe |=> !irqRequest)
    else $error("request kept while source in service");
endmodule

bind fifo_irq_status fifo_irq_status_checker u_chk (.ref_clk(ref_clk), .rstn(rstn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .irq_acknowledge_in_n(irq_acknowledge_in_n), .mailboxToOther(mailboxToOther),
  .mailboxToOtherStrobe(mailboxToOtherStrobe), .irqRequest(irqRequest),
  .vectorOut(vectorOut), .vectorOe(vectorOe));

// *** opposite_port_model.sv ***
// Model of the opposite port's mailbox side.
// Assumes the caller enters send just after a rising edge.
`timescale 1ns/1ps
module opposite_port_model (
  input wire logic ref_clk,
  input wire logic [7:0] mailboxToOther,
  input wire logic mailboxToOtherStrobe,
  output logic [7:0] mailboxFromOther,
  output logic mailboxFromOtherStrobe,
  output logic [7:0] lastRx
);
  initial begin
    mailboxFromOther = 8'h00;
    mailboxFromOtherStrobe = 1'b0;
    lastRx = 8'h00;
  end
  always @(posedge ref_clk) begin
    if (mailboxToOtherStrobe) lastRx <= mailboxToOther;
  end
  task automatic send(input logic [7:0] b, input int gap);
    repeat (gap) @(posedge ref_clk);
    mailboxFromOther <= b;
    mailboxFromOtherStrobe <= 1'b1;
    @(posedge ref_clk);
    mailboxFromOtherStrobe <= 1'b0;
    // Inverted so a stale byte is never mistaken for valid data
    mailboxFromOther <= ~b;
  endtask
endmodule

// *** tb_fifo_irq_status.sv ***
// Self-checking bench for the FIFO port interrupt block.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
module tb_fifo_irq_status
  import fifo_irq_pkg::*;
;
  logic ref_clk, rstn, hsel, hwrite, hreadyout, hresp, bytePassed, bufferFull, bufferEmpty;
  logic fullPin, emptyPin, twoWireMode, peripheralMode, waitSelected, writeAttempt;
  logic readAttempt, directionChanged, mbStb, ackN, toStb, irqRequest, vectorOe, fc, ec;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] dataByte, byteCount, byteCountCompare, mbIn, toOther, vectorOut, rx, v, p, m, d;
  int n_fail, tests_run, seed, k;
  // Expected mailbox bytes, oldest first
  logic [7:0] mbq[$];

  fifo_irq_status DUT (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dataByte(dataByte),
    .bytePassed(bytePassed), .byteCount(byteCount), .byteCountCompare(byteCountCompare),
    .bufferFull(bufferFull), .bufferEmpty(bufferEmpty), .fullPin(fullPin),
    .emptyPin(emptyPin), .twoWireMode(twoWireMode), .peripheralMode(peripheralMode),
    .waitSelected(waitSelected), .writeAttempt(writeAttempt), .readAttempt(readAttempt),
    .directionChanged(directionChanged), .mailboxFromOther(mbIn),
    .mailboxFromOtherStrobe(mbStb), .irq_acknowledge_in_n(ackN), .mailboxToOther(toOther),
    .mailboxToOtherStrobe(toStb), .irqRequest(irqRequest), .vectorOut(vectorOut),
    .vectorOe(vectorOe));
  opposite_port_model peer (.ref_clk(ref_clk), .mailboxToOther(toOther),
    .mailboxToOtherStrobe(toStb), .mailboxFromOther(mbIn), .mailboxFromOtherStrobe(mbStb),
    .lastRx(rx));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // Master waits on hready only; the bound stands in for a hung slave
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int t;
    t = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do begin
      @(posedge ref_clk);
      t++;
    end while (hreadyout !== 1'b1 && t < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge ref_clk);
      t++;
    end while (hreadyout !== 1'b1 && t < 20);
    rd = hrdata;
    if (t >= 20) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] b);
    bus(1'b1, a, {24'h0, b});
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, rd, {24'h0, exp});
  endtask
  task automatic wait_irq(input logic exp);
    int t;
    t = 0;
    while (irqRequest !== exp && t < 8) begin
      @(posedge ref_clk);
      t++;
    end
    chk("irqRequest", {31'h0, irqRequest}, {31'h0, exp});
    if (t >= 8) summarize();
  endtask
  task automatic ack(input logic oe, input logic [7:0] vec);
    ackN <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("vectorOe", {31'h0, vectorOe}, {31'h0, oe});
    if (oe) chk("vectorOut", {24'h0, vectorOut}, {24'h0, vec});
    ackN <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {hsel, hwrite, bytePassed, bufferFull, bufferEmpty, fullPin, emptyPin} = 7'h00;
    {twoWireMode, peripheralMode, waitSelected, writeAttempt, readAttempt} = 5'h00;
    {directionChanged, rstn} = 2'h0;
    ackN = 1'b1;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    {dataByte, byteCount} = 16'h0;
    byteCountCompare = 8'h01;
    seed = 32'h7CA1934A;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rdchk("mask", PAT_MASK_ADDR, 8'h00);
    rdchk("status0", ISR0_ADDR, 8'h00);
    rdchk("status2", ISR2_ADDR, 8'h00);
    rdchk("unmapped", 8'h40, 8'h00);
    wr(ISR1_ADDR, 8'h00);
    wr(PAT_MASK_ADDR, 8'hFF);
    rdchk("flag", ISR1_ADDR, 8'h01);
    for (int i = 0; i < 12; i++) begin
      p = 8'($random(seed));
      m = (i < 3) ? 8'h00 : 8'($random(seed));
      d = 8'($random(seed));
      d = i[0] ? p ^ (d & m) : d;
      dataByte <= d;
      wr(PAT_BYTE_ADDR, p);
      wr(PAT_MASK_ADDR, m);
      rdchk("flag", ISR1_ADDR, {7'h0, ((d ^ p) & ~m) == 8'h0});
    end
    wr(PAT_MASK_ADDR, 8'h00);
    wr(ISR1_ADDR, 8'h04);
    for (int i = 0; i < 2; i++) begin
      dataByte <= i[0] ? p : ~p;
      bytePassed <= 1'b1;
      @(posedge ref_clk);
      bytePassed <= 1'b0;
      rdchk("pattern", ISR1_ADDR, i[0] ? 8'h07 : 8'h04);
    end
    v = 8'($random(seed));
    mbq.push_back(v);
    wr(MBOX_OUT_ADDR, v);
    repeat (3) @(posedge ref_clk);
    chk("sent", {24'h0, rx}, {24'h0, mbq.pop_front()});
    mbq.push_back(v ^ 8'h5A);
    peer.send(v ^ 8'h5A, 3);
    rdchk("msgPending", ISR0_ADDR, 8'h20);
    rdchk("msgIn", MBOX_IN_ADDR, mbq.pop_front());
    rdchk("msgDone", ISR0_ADDR, 8'h00);
    waitSelected <= 1'b1;
    bufferFull <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      writeAttempt <= 1'b1;
      readAttempt <= !i[0];
      bufferEmpty <= !i[0];
      @(posedge ref_clk);
      writeAttempt <= 1'b0;
      readAttempt <= 1'b0;
      waitSelected <= 1'b0;
      rdchk("overflow", ISR2_ADDR, i[0] ? 8'h12 : 8'h00);
    end
    wr(ISR2_ADDR, 8'h00);
    rdchk("errClear", ISR2_ADDR, 8'h00);
    bufferFull <= 1'b0;
    bufferEmpty <= 1'b1;
    readAttempt <= 1'b1;
    @(posedge ref_clk);
    readAttempt <= 1'b0;
    bufferEmpty <= 1'b0;
    rdchk("underflow", ISR2_ADDR, 8'h03);
    wr(ISR2_ADDR, 8'h00);
    byteCount <= 8'h05;
    byteCountCompare <= 8'h05;
    rdchk("count", ISR2_ADDR, 8'h20);
    byteCountCompare <= 8'h06;
    wr(CTRL_ADDR, 8'h03);
    wr(VECTOR_ADDR, v);
    for (int c = 7; c >= 0; c--) begin
      for (int r = 0; r < 4; r++) wr(ISR0_ADDR + 8'(4 * r), 8'h00);
      if (c > 0) wr(ISR0_ADDR + 8'(4 * ((8 - c) / 2)), (c == 7 || !c[0]) ? 8'h60 : 8'h06);
      rdchk("code", VECTOR_ADDR, {v[7:4], 3'(c), v[0]});
      wait_irq(c > 0);
    end
    wr(ISR1_ADDR, 8'h40);
    wr(ISR0_ADDR, 8'h40);
    directionChanged <= 1'b1;
    @(posedge ref_clk);
    directionChanged <= 1'b0;
    peer.send(8'h3C, 0);
    rdchk("priority", VECTOR_ADDR, {v[7:4], 3'h7, v[0]});
    ack(1'b1, {v[7:4], 3'h7, v[0]});
    rdchk("inService", ISR0_ADDR, 8'hE0);
    wait_irq(1'b0);
    wr(ISR0_ADDR, 8'h00);
    wait_irq(1'b1);
    wr(CTRL_ADDR, 8'h01);
    ack(1'b1, v);
    wr(CTRL_ADDR, 8'h00);
    rdchk("baseVector", VECTOR_ADDR, v);
    ack(1'b0, v);
    for (int i = 0; i < 16; i++) begin
      k = $random(seed);
      {bufferFull, fullPin, twoWireMode, bufferEmpty, emptyPin, peripheralMode} <= 6'(k);
      fc = k[5] & (~k[3] | k[4]);
      ec = k[2] & (~k[0] | k[1]);
      wr(ISR3_ADDR, 8'h00);
      rdchk("fullEmpty", ISR3_ADDR, {2'b00, fc, fc, 2'b00, ec, ec});
    end
    summarize();
  end
endmodule
